// file: adf_map.svh
// Register map, field layout and timing constants of the filter control.
// Assumes a 200 MHz system clock and a 32-bit plain register port.
// Notes on behaviour
// R1: A filter register write resets all converters; 60 us more per enabled one.
// R2: Bit 15 turns on system chopping; averaging zero gives one third rate.
// R3: With a nonzero averaging factor chopping adds three ticks to the period.
// R4: With chopping on, the filter settles in two output periods.
// R5: Software enables chopping only with a decimation factor above one.
// R6: Bit 14 turns on a two-result running average, forced on while chopping.
// R7: Running average alone keeps the rate but adds one settling period.
// R8: Bits 13 to 8 hold the six-bit averaging factor of the post filter.
// R9: No chop, averaging on: rate is 512000 / ((dec+1) * 64 * (avg+3)).
// R10: Bit 7 adds a second notch at 1.333 times the first notch.
// R11: Bits 6 to 0 hold the decimation factor; rate 512000 / ((dec+1) * 64).
// R12: Decimation code 126 forces 60 Hz, code 127 forces 50 Hz.
// R13: Chopping on: rate is 512000 / ((dec+1) * 64 * (avg+3) + 3).
// R14: Settling periods: 3 plain, 1 averaging, 4 running, 2 both or chopped.
// R15: Software keeps legal pairs of decimation and averaging factors.
// R16: Lowest rate is 4 Hz in normal power and 1 Hz in low power.
// R17: With all three converters on, software sets decimation factor one or more.
// R18: Low-power modes run the filter from the 131 kHz oscillator instead.
// R19: Software raises the decimation factor before it uses averaging.
// R20: A register write clears all integrator and averaging state.
`ifndef ADF_MAP_SVH
`define ADF_MAP_SVH

`define ADF_FLT_ADDR 32'hffff0518
`define ADF_STAT_ADDR 32'hffff0580
`define ADF_FLT_RESET 16'h0007

`define ADF_CHOP_BIT 15
`define ADF_RAVG_BIT 14
`define ADF_AF_MSB 13
`define ADF_AF_LSB 8
`define ADF_NOTCH_BIT 7
`define ADF_SF_MSB 6
`define ADF_SF_LSB 0

`define ADF_ST_STARTING_BIT 0
`define ADF_ST_SETTLING_BIT 1
`define ADF_ST_RUNNING_BIT 2
`define ADF_ST_CHOP_BIT 3
`define ADF_ST_SETTLE_LSB 4
`define ADF_ST_SETTLE_MSB 6

`define ADF_CLK_HZ 200000000
`define ADF_CLK_PERIOD_NS 5
`define ADF_MOD_HZ 512000
`define ADF_LP_HZ 131000
`define ADF_START_US 60

`define ADF_SF_60HZ 7'h7e
`define ADF_SF_50HZ 7'h7f
`define ADF_TICKS_60HZ 21'h002155
`define ADF_TICKS_50HZ 21'h002800
`define ADF_SINC_OSR 21'h000040
`define ADF_AF_OFFSET 21'h000003
`define ADF_CHOP_EXTRA 21'h000003
`define ADF_MAX_PERIOD_TICKS 21'h01f400

`define ADF_SETTLE_PLAIN 3'h3
`define ADF_SETTLE_AVG 3'h1
`define ADF_SETTLE_RAVG 3'h4
`define ADF_SETTLE_BOTH 3'h2
`define ADF_SETTLE_CHOP 3'h2

`endif

// file: adf_pkg.sv
// Types shared by the filter control and its tick generator.
// Assumes adf_map.svh supplies all numeric constants.
`default_nettype none
package adf_pkg;
	typedef enum {ADF_ST_LOAD, ADF_ST_START, ADF_ST_SETTLE, ADF_ST_RUN} adf_state_t;
	typedef logic [20:0] adf_ticks_t;
	typedef logic [2:0] adf_settle_t;
endpackage
`default_nettype wire

// file: adf_tick_gen.sv
// Modulator-rate enable generator: a phase accumulator on the system clock.
// Assumes low_power_in comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adf_map.svh"
module adf_tick_gen (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic low_power_in,
	output logic tick_out
);
	import adf_pkg::*;

	// Fractional step keeps the mean rate exact; jitter is one system cycle
	localparam logic [31:0] STEP_NORMAL =
		32'((64'(`ADF_MOD_HZ) << 32) / 64'(`ADF_CLK_HZ));
	localparam logic [31:0] STEP_LOW =
		32'((64'(`ADF_LP_HZ) << 32) / 64'(`ADF_CLK_HZ));

	logic [31:0] acc_q;
	logic [31:0] acc_d;
	logic tick_q;
	logic tick_d;
	logic [32:0] sum;

	always_comb begin
		sum = {1'b0, acc_q} +
			{1'b0, (low_power_in ? STEP_LOW : STEP_NORMAL)}; // R18
		acc_d = sum[31:0];
		tick_d = sum[32];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;
endmodule // adf_tick_gen
`default_nettype wire

// file: adf_filter_ctrl.sv
// Decimation filter control: filter register, output period timing,
// start-up delay after a register write and settling before valid results.
// Assumes the sinc3 datapath sits outside and follows the strobes given here;
// adc_en_in and low_power_in come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adf_map.svh"
module adf_filter_ctrl #(
	parameter int unsigned START_CYCLES =
		(`ADF_START_US * 1000 + `ADF_CLK_PERIOD_NS - 1) / `ADF_CLK_PERIOD_NS
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [2:0] adc_en_in,
	input wire logic low_power_in,
	output logic conv_reset_out,
	output logic filter_clear_out,
	output logic mod_tick_out,
	output logic result_valid_out,
	output logic chop_phase_out,
	output logic run_avg_out,
	output logic second_notch_out,
	output logic [6:0] decim_factor_out,
	output logic [5:0] avg_factor_out,
	output adf_pkg::adf_ticks_t period_ticks_out
);
	import adf_pkg::*;

	// Output period in modulator ticks for a register value
	function automatic adf_ticks_t calc_period(input logic [15:0] f);
		logic [6:0] sf;
		logic [5:0] af;
		logic chop;
		adf_ticks_t mult;
		adf_ticks_t t;
		sf = f[`ADF_SF_MSB:`ADF_SF_LSB];
		af = f[`ADF_AF_MSB:`ADF_AF_LSB];
		chop = f[`ADF_CHOP_BIT];
		// Chopping with averaging at zero still multiplies by three
		if (af != 6'h0 || chop) begin // R2 R3
			mult = 21'({15'h0, af}) + `ADF_AF_OFFSET; // R8 R9
		end else begin
			mult = 21'h1;
		end
		t = 21'(21'({14'h0, sf}) + 21'h1) * `ADF_SINC_OSR * mult; // R11 R9
		if (chop) begin
			t = t + `ADF_CHOP_EXTRA; // R13
		end
		if (sf == `ADF_SF_60HZ) begin
			t = `ADF_TICKS_60HZ; // R12
		end else if (sf == `ADF_SF_50HZ) begin
			t = `ADF_TICKS_50HZ; // R12
		end
		// Illegal factor pairs could run slower than the datapath allows
		if (t > `ADF_MAX_PERIOD_TICKS) begin
			t = `ADF_MAX_PERIOD_TICKS; // R16
		end
		return t;
	endfunction

	// Output periods up to and including the first valid result
	function automatic adf_settle_t calc_settle(input logic [15:0] f);
		logic af_on;
		logic ra;
		adf_settle_t s;
		af_on = f[`ADF_AF_MSB:`ADF_AF_LSB] != 6'h0;
		ra = f[`ADF_RAVG_BIT];
		if (f[`ADF_CHOP_BIT]) begin
			s = `ADF_SETTLE_CHOP; // R4 R14
		end else if (ra && af_on) begin
			s = `ADF_SETTLE_BOTH; // R14
		end else if (ra) begin
			s = `ADF_SETTLE_RAVG; // R7 R14
		end else if (af_on) begin
			s = `ADF_SETTLE_AVG; // R14
		end else begin
			s = `ADF_SETTLE_PLAIN; // R14
		end
		return s;
	endfunction

	logic mod_tick;

	adf_tick_gen u_tick (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.low_power_in(low_power_in),
		.tick_out(mod_tick)
	);

	// Register group
	logic [15:0] flt_q;
	logic [15:0] flt_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wr_flt;
	logic [31:0] status;

	// Control group
	adf_state_t state_q;
	adf_state_t state_d;
	logic [31:0] start_cnt_q;
	logic [31:0] start_cnt_d;
	logic [1:0] adc_left_q;
	logic [1:0] adc_left_d;
	adf_ticks_t tick_cnt_q;
	adf_ticks_t tick_cnt_d;
	adf_ticks_t period_q;
	adf_ticks_t period_d;
	adf_settle_t settle_q;
	adf_settle_t settle_d;
	logic chop_phase_q;
	logic chop_phase_d;
	logic valid_q;
	logic valid_d;
	logic conv_reset_q;
	logic conv_reset_d;
	logic clear_q;
	logic clear_d;
	logic ravg_q;
	logic ravg_d;
	logic notch_q;
	logic notch_d;
	logic period_end;

	always_comb begin
		wr_flt = wr_in && (addr_in == `ADF_FLT_ADDR);
		flt_d = wr_flt ? wdata_in[15:0] : flt_q;
		status = 32'h0;
		status[`ADF_ST_STARTING_BIT] = (state_q == ADF_ST_LOAD) ||
			(state_q == ADF_ST_START);
		status[`ADF_ST_SETTLING_BIT] = (state_q == ADF_ST_SETTLE);
		status[`ADF_ST_RUNNING_BIT] = (state_q == ADF_ST_RUN);
		status[`ADF_ST_CHOP_BIT] = chop_phase_q;
		status[`ADF_ST_SETTLE_MSB:`ADF_ST_SETTLE_LSB] = settle_q;
		rdata_d = 32'h0;
		if (rd_in) begin
			case (addr_in)
				`ADF_FLT_ADDR: begin
					rdata_d = {16'h0, flt_q};
				end
				`ADF_STAT_ADDR: begin
					rdata_d = status;
				end
				default: begin
					rdata_d = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flt_q <= `ADF_FLT_RESET;
			rdata_q <= 32'h0;
		end else begin
			flt_q <= flt_d;
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		state_d = state_q;
		start_cnt_d = start_cnt_q;
		adc_left_d = adc_left_q;
		tick_cnt_d = tick_cnt_q;
		settle_d = settle_q;
		chop_phase_d = chop_phase_q;
		valid_d = 1'b0;
		conv_reset_d = 1'b0;
		clear_d = 1'b0;
		period_d = calc_period(flt_q);
		ravg_d = flt_q[`ADF_RAVG_BIT] | flt_q[`ADF_CHOP_BIT]; // R6
		notch_d = flt_q[`ADF_NOTCH_BIT]; // R10
		period_end = mod_tick && (tick_cnt_q >= period_q - 21'h1);
		if (wr_flt) begin
			// Any write restarts everything, even with an unchanged value
			state_d = ADF_ST_LOAD;
			conv_reset_d = 1'b1; // R1
			clear_d = 1'b1; // R20
			start_cnt_d = 32'h0;
			tick_cnt_d = 21'h0;
			chop_phase_d = 1'b0; // R20
		end else begin
			case (state_q)
				ADF_ST_LOAD: begin
					adc_left_d = 2'({1'b0, adc_en_in[0]} + {1'b0, adc_en_in[1]} +
						{1'b0, adc_en_in[2]}); // R1
					start_cnt_d = 32'h0;
					state_d = ADF_ST_START;
				end
				ADF_ST_START: begin
					if (adc_left_q == 2'h0) begin
						// Without an enabled converter there is nothing to time
						if (|adc_en_in) begin
							state_d = ADF_ST_SETTLE;
							settle_d = calc_settle(flt_q); // R14
							tick_cnt_d = 21'h0;
						end
					end else if (start_cnt_q == 32'(START_CYCLES - 1)) begin
						start_cnt_d = 32'h0;
						adc_left_d = adc_left_q - 2'h1; // R1
					end else begin
						start_cnt_d = start_cnt_q + 32'h1;
					end
				end
				ADF_ST_SETTLE, ADF_ST_RUN: begin
					if (mod_tick) begin
						tick_cnt_d = period_end ? 21'h0 : tick_cnt_q + 21'h1;
					end
					if (period_end) begin
						if (flt_q[`ADF_CHOP_BIT]) begin
							chop_phase_d = ~chop_phase_q; // R2
						end
						if (state_q == ADF_ST_RUN) begin
							valid_d = 1'b1;
						end else if (settle_q <= 3'h1) begin
							state_d = ADF_ST_RUN;
							settle_d = 3'h0;
							valid_d = 1'b1; // R14
						end else begin
							settle_d = settle_q - 3'h1; // R4 R7
						end
					end
				end
				default: begin
					state_d = ADF_ST_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ADF_ST_LOAD;
			start_cnt_q <= 32'h0;
			adc_left_q <= 2'h0;
			tick_cnt_q <= 21'h0;
			period_q <= 21'h0;
			settle_q <= 3'h0;
			chop_phase_q <= 1'b0;
			valid_q <= 1'b0;
			conv_reset_q <= 1'b0;
			clear_q <= 1'b0;
			ravg_q <= 1'b0;
			notch_q <= 1'b0;
		end else begin
			state_q <= state_d;
			start_cnt_q <= start_cnt_d;
			adc_left_q <= adc_left_d;
			tick_cnt_q <= tick_cnt_d;
			period_q <= period_d;
			settle_q <= settle_d;
			chop_phase_q <= chop_phase_d;
			valid_q <= valid_d;
			conv_reset_q <= conv_reset_d;
			clear_q <= clear_d;
			ravg_q <= ravg_d;
			notch_q <= notch_d;
		end
	end

	assign rdata_out = rdata_q;
	assign conv_reset_out = conv_reset_q;
	assign filter_clear_out = clear_q;
	assign mod_tick_out = mod_tick;
	assign result_valid_out = valid_q;
	assign chop_phase_out = chop_phase_q;
	assign run_avg_out = ravg_q;
	assign second_notch_out = notch_q;
	assign decim_factor_out = flt_q[`ADF_SF_MSB:`ADF_SF_LSB];
	assign avg_factor_out = flt_q[`ADF_AF_MSB:`ADF_AF_LSB];
	assign period_ticks_out = period_q;
endmodule // adf_filter_ctrl
`default_nettype wire

// file: adf_filter_ctrl_chk.sv
// Port checker for the filter control.
// Assumes it is bound to adf_filter_ctrl.
`timescale 1ns/1ps
`default_nettype none
`include "adf_map.svh"
module adf_filter_ctrl_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic conv_reset_out,
	input wire logic filter_clear_out,
	input wire logic result_valid_out,
	input wire logic chop_phase_out,
	input wire logic run_avg_out,
	input wire logic second_notch_out,
	input wire logic [6:0] decim_factor_out,
	input wire logic [5:0] avg_factor_out,
	input wire adf_pkg::adf_ticks_t period_ticks_out
);
	import adf_pkg::*;
	logic fw;
	assign fw = wr_in && addr_in == `ADF_FLT_ADDR;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	chk_write_resets: assert property (fw |=> conv_reset_out)
		else $error("no converter reset after write");
	chk_clear_pair: assert property (filter_clear_out |->
		conv_reset_out && $past(fw))
		else $error("state clear without write");
	chk_chop_clear: assert property (conv_reset_out |-> !chop_phase_out)
		else $error("chop phase not cleared by write");
	chk_start_gap: assert property (conv_reset_out |-> !result_valid_out [*6])
		else $error("result too soon after write");
	chk_chop_avg: assert property (fw && wdata_in[15] ##1 !fw |=> run_avg_out)
		else $error("running average not forced");
	chk_notch_bit: assert property (fw ##1 !fw |=>
		second_notch_out == $past(wdata_in[7], 2))
		else $error("notch bit wrong");
	chk_field_copy: assert property (fw ##1 !fw |=>
		decim_factor_out == $past(wdata_in[6:0], 2) &&
		avg_factor_out == $past(wdata_in[13:8], 2))
		else $error("factor fields wrong");
	chk_forced_60: assert property (fw && wdata_in[6:0] == 7'h7e ##1 !fw
		|=> period_ticks_out == 21'h002155)
		else $error("60 Hz period wrong");
	chk_forced_50: assert property (fw && wdata_in[6:0] == 7'h7f ##1 !fw
		|=> period_ticks_out == 21'h002800)
		else $error("50 Hz period wrong");
	chk_plain_rate: assert property (fw && wdata_in[15:8] == 8'h00 &&
		wdata_in[6:0] < 7'h7e ##1 !fw |=>
		period_ticks_out == ({14'h0, $past(wdata_in[6:0], 2)} + 21'h1) << 6)
		else $error("plain period wrong");
	chk_valid_pulse: assert property (result_valid_out |=> !result_valid_out)
		else $error("result strobe too long");
endmodule // adf_filter_ctrl_chk
`default_nettype wire

// file: adf_mod_model.sv
// Behavioural model of the three modulators behind the filter control.
// Assumes conv_reset_in and mod_tick_in are one-cycle pulses on clk_in.
`timescale 1ns/1ps
`default_nettype none
module adf_mod_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [2:0] en_sel_in,
	input wire logic conv_reset_in,
	input wire logic mod_tick_in,
	output logic [2:0] adc_en_out,
	output logic [15:0] samples_out
);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			adc_en_out <= 3'h0;
			samples_out <= 16'h0;
		end else begin
			adc_en_out <= en_sel_in;
			// A reset converter restarts its sample stream from zero
			if (conv_reset_in) begin
				samples_out <= 16'h0;
			end else if (mod_tick_in && adc_en_out != 3'h0) begin
				samples_out <= samples_out + 16'h1;
			end
		end
	end
endmodule // adf_mod_model
`default_nettype wire

// file: adc_decimation_filter_control_tb.sv
// Self-checking bench for the filter control with a modulator model.
// Assumes START_CYCLES is shortened to 4.
`timescale 1ns/1ps
`default_nettype none
`include "adf_map.svh"
module adc_decimation_filter_control_tb;
	import adf_pkg::*;
	logic clk_in, rst_in, wr_in, rd_in, low_power_in, conv_reset_out;
	logic filter_clear_out, mod_tick_out, result_valid_out, chop_phase_out;
	logic run_avg_out, second_notch_out;
	logic [31:0] addr_in, wdata_in, rdata_out;
	logic [2:0] en_sel, adc_en;
	logic [6:0] decim_factor_out;
	logic [5:0] avg_factor_out;
	adf_ticks_t period_ticks_out;
	logic [15:0] samples;
	int n_mismatch, cmp_count, cycles;
	adf_filter_ctrl #(.START_CYCLES(4)) i_dut (.clk_in(clk_in),
		.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.adc_en_in(adc_en), .low_power_in(low_power_in),
		.conv_reset_out(conv_reset_out), .filter_clear_out(filter_clear_out),
		.mod_tick_out(mod_tick_out), .result_valid_out(result_valid_out),
		.chop_phase_out(chop_phase_out), .run_avg_out(run_avg_out),
		.second_notch_out(second_notch_out), .decim_factor_out(decim_factor_out),
		.avg_factor_out(avg_factor_out), .period_ticks_out(period_ticks_out));
	adf_mod_model i_mod (.clk_in(clk_in), .rst_in(rst_in), .en_sel_in(en_sel),
		.conv_reset_in(conv_reset_out), .mod_tick_in(mod_tick_out),
		.adc_en_out(adc_en), .samples_out(samples));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic bad(input string m);
		n_mismatch++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic cmp32(input logic [31:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) bad(m);
	endtask
	task automatic cmp_rng(input logic [31:0] got, lo, hi, input string m);
		cmp_count++;
		if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) bad(m);
	endtask
	task automatic wr(input logic [31:0] a, d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_reset;
		logic [31:0] d;
		rd(`ADF_FLT_ADDR, d);
		cmp32(d, 32'h7, "reset value");
		rd(32'hffff0600, d);
		cmp32(d, 32'h0, "unmapped read");
		rd(`ADF_STAT_ADDR, d);
		cmp32(d, 32'h1, "status after reset");
		cmp32({11'h0, period_ticks_out}, 32'h200, "reset period");
		$display("reset test done");
	endtask
	task automatic t_fields;
		logic [15:0] w [8] = '{16'h0007, 16'h007e, 16'h007f, 16'h007d,
			16'h0203, 16'h8002, 16'h4087, 16'h3f1f};
		logic [20:0] p [8] = '{21'h000200, 21'h002155, 21'h002800,
			21'h001f80, 21'h000500, 21'h000243, 21'h000200, 21'h01f400};
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			wr(`ADF_FLT_ADDR, {16'hffff, w[i]});
			@(posedge clk_in);
			#1;
			cmp32({11'h0, period_ticks_out}, {11'h0, p[i]}, "period");
			cmp32({17'h0, run_avg_out, avg_factor_out, second_notch_out,
				decim_factor_out}, {17'h0, w[i][15] | w[i][14], w[i][13:0]},
				"fields");
			rd(`ADF_FLT_ADDR, d);
			cmp32(d, {16'h0, w[i]}, "readback");
		end
		$display("field test done");
	endtask
	task automatic t_lowpow;
		int k;
		for (int lp = 0; lp < 2; lp++) begin
			low_power_in <= lp[0];
			repeat (2) @(posedge clk_in);
			k = 0;
			repeat (4000) begin
				@(posedge clk_in);
				#1;
				if (mod_tick_out === 1'b1) k++;
			end
			cmp_rng(k, lp ? 32'h2 : 32'ha, lp ? 32'h3 : 32'hb, "tick rate");
		end
		low_power_in <= 1'b0;
		$display("low power test done");
	endtask
	task automatic t_settle;
		int t;
		en_sel <= 3'h1;
		wr(`ADF_FLT_ADDR, 32'h0);
		t = 0;
		while (result_valid_out !== 1'b1 && t < 90000) begin
			@(posedge clk_in);
			#1;
			t++;
		end
		cmp_rng({16'h0, samples}, 32'hc0, 32'hc1, "settle time");
		$display("settle test done");
	endtask
	initial begin
		rst_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 32'h0;
		wdata_in = 32'h0;
		en_sel = 3'h0;
		low_power_in = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset;
		t_fields;
		t_lowpow;
		t_settle;
		test_done;
	end
	// Settling alone takes about 75000 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 99000) begin
			n_mismatch++;
			test_done;
		end
	end
endmodule // adc_decimation_filter_control_tb
bind adf_filter_ctrl adf_filter_ctrl_chk i_chk (.clk_in(clk_in),
	.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.conv_reset_out(conv_reset_out), .filter_clear_out(filter_clear_out),
	.result_valid_out(result_valid_out), .chop_phase_out(chop_phase_out),
	.run_avg_out(run_avg_out),
	.second_notch_out(second_notch_out), .decim_factor_out(decim_factor_out),
	.avg_factor_out(avg_factor_out), .period_ticks_out(period_ticks_out));
`default_nettype wire
